/* File: logic/cla_pkg.sv */
`default_nettype none

package cla_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned T_EXEC_NS     = 37000;
	localparam int unsigned T_LONG_NS     = 1520000;
	localparam int unsigned T_POR_MS      = 40;
	localparam int unsigned EXEC_CYC =
		(T_EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LONG_CYC =
		(T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POR_CYC =
		(T_POR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 24;

	// ----------------------------------------------------------------
	// memory map
	// ----------------------------------------------------------------
	localparam int unsigned TXT_DEPTH    = 128;
	localparam int unsigned GLY_DEPTH    = 64;
	localparam logic [6:0]  TXT_ONE_LAST = 7'h4f;
	localparam logic [6:0]  TXT_L1_LAST  = 7'h27;
	localparam logic [6:0]  TXT_L2_FIRST = 7'h40;
	localparam logic [6:0]  TXT_L2_LAST  = 7'h67;
	localparam logic [6:0]  TXT_TOP      = 7'h7f;
	localparam logic [7:0]  SPACE_CODE   = 8'h20;

	// ----------------------------------------------------------------
	// instruction byte: highest set bit selects the instruction
	// ----------------------------------------------------------------
	localparam int unsigned OP_TXT_ADDR = 7;
	localparam int unsigned OP_GLY_ADDR = 6;
	localparam int unsigned OP_FUNC     = 5;
	localparam int unsigned OP_SHIFT    = 4;
	localparam int unsigned OP_DISPLAY  = 3;
	localparam int unsigned OP_ENTRY    = 2;
	localparam int unsigned OP_HOME     = 1;
	localparam int unsigned OP_CLEAR    = 0;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_CLEAR = 2'b10
	} cla_state_e;

	typedef struct packed {
		logic       register_select;
		logic       read_write;
		logic       strobe;
		logic [7:0] data_lines;
	} cla_host_s;

	typedef struct packed {
		logic bus_width_select;
		logic two_line;
		logic font_5x11;
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic increment;
		logic shift_on;
	} cla_cfg_s;

	// after power-on: 8-bit, one line, 5x8, all off, increment, no shift
	localparam cla_cfg_s CFG_RESET = '{
		bus_width_select: 1'b1, two_line: 1'b0, font_5x11: 1'b0,
		display_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0,
		increment: 1'b1, shift_on: 1'b0};

endpackage

`default_nettype wire

/* File: logic/cla_core.sv */
`timescale 1ns/1ps
`default_nettype none

module cla_core
	import cla_pkg::*;
#(
	parameter int unsigned EXEC_CYCLES = EXEC_CYC,
	parameter int unsigned LONG_CYCLES = LONG_CYC,
	parameter int unsigned POR_CYCLES  = POR_CYC
)(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// host parallel bus
	input  wire cla_host_s  i_host,
	output var  logic [7:0] o_data_lines,
	output var  logic       o_data_lines_oe,
	// status
	output var  logic       o_busy_indicator,
	output var  logic [6:0] o_address_counter,
	output var  logic       o_glyph_selected,
	output var  cla_cfg_s   o_cfg,
	// panel scan
	input  wire logic [3:0] i_panel_pos,
	output var  logic [7:0] o_panel_code
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cla_state_e             state_q, state_d;
	logic [CNT_W-1:0]       cnt_q, cnt_d;
	logic [6:0]             clr_q, clr_d;
	logic [6:0]             ac_q, ac_d;
	logic                   sel_q, sel_d;
	cla_cfg_s               cfg_q, cfg_d;
	logic [7:0]             latch_q, latch_d;
	logic                   nib_q, nib_d;
	logic [3:0]             hold_q, hold_d;
	logic                   strb_q;
	logic [7:0]             dout_q, dout_d;
	logic                   oe_q, oe_d;
	logic                   busy_q, busy_d;
	logic [7:0]             panel_q, panel_d;
	logic [7:0]             txt_q [TXT_DEPTH];
	logic [7:0]             gly_q [GLY_DEPTH];
	logic                   txt_we, gly_we;
	logic [6:0]             wa;
	logic [7:0]             wd;
	logic                   rise, fall, done, acc;
	logic [7:0]             byte_in;
	logic [7:0]             rv;
	logic [6:0]             nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [6:0] step_ac(input logic [6:0] a,
		input logic up, input logic glyph, input logic two);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (glyph)
		begin
			r = {1'b0, r[5:0]};
		end
		else if (!two)
		begin
			if (up && a == TXT_ONE_LAST) r = 7'h00;
			if (!up && a == 7'h00) r = TXT_ONE_LAST;
		end
		else
		begin
			if (up && a == TXT_L1_LAST) r = TXT_L2_FIRST;
			if (up && a == TXT_L2_LAST) r = 7'h00;
			if (!up && a == TXT_L2_FIRST) r = TXT_L1_LAST;
			if (!up && a == 7'h00) r = TXT_L2_LAST;
		end
		return r;
	endfunction

	function automatic logic [7:0] mem_rd(input logic glyph,
		input logic [6:0] a);
		return glyph ? gly_q[a[5:0]] : txt_q[a];
	endfunction

	// ----------------------------------------------------------------
	// bus strobe and nibble assembly
	// ----------------------------------------------------------------
	// strobe is taken as synchronous; transfers act on its falling edge
	assign rise = i_host.strobe && !strb_q;
	assign fall = !i_host.strobe && strb_q;
	assign done = fall && (cfg_q.bus_width_select || nib_q);
	// upper nibble arrives first on data lines 7..4
	assign byte_in = cfg_q.bus_width_select ? i_host.data_lines
		: {hold_q, i_host.data_lines[7:4]};
	// status reads are always answered; all else is dropped while busy
	assign acc = done && !busy_q
		&& !(i_host.read_write && !i_host.register_select);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		clr_d   = clr_q;
		ac_d    = ac_q;
		sel_d   = sel_q;
		cfg_d   = cfg_q;
		latch_d = latch_q;
		nib_d   = nib_q;
		hold_d  = hold_q;
		dout_d  = dout_q;
		oe_d    = oe_q;
		txt_we  = 1'b0;
		gly_we  = 1'b0;
		wa      = ac_q;
		wd      = byte_in;
		nxt     = step_ac(ac_q, cfg_q.increment, sel_q, cfg_q.two_line);
		rv      = i_host.register_select ? latch_q
			: {busy_q, ac_q};
		panel_d = txt_q[{i_panel_pos[3], 3'b000, i_panel_pos[2:0]}];

		if (fall && !cfg_q.bus_width_select)
		begin
			nib_d = !nib_q;
			if (!nib_q)
				hold_d = i_host.data_lines[7:4];
		end
		if (rise && i_host.read_write)
		begin
			oe_d = 1'b1;
			if (cfg_q.bus_width_select)
				dout_d = rv;
			else
				dout_d = nib_q ? {rv[3:0], 4'h0} : {rv[7:4], 4'h0};
		end
		else if (fall)
		begin
			oe_d = 1'b0;
		end

		case (state_q)
			ST_IDLE:
			begin
				if (acc)
				begin
					state_d = ST_EXEC;
					cnt_d   = CNT_W'(EXEC_CYCLES);
					if (i_host.register_select && !i_host.read_write)
					begin
						txt_we = !sel_q;
						gly_we = sel_q;
						ac_d   = nxt;
						// latch left alone: read-back needs re-addressing
					end
					else if (i_host.register_select)
					begin
						ac_d    = nxt;
						latch_d = mem_rd(sel_q, nxt);
					end
					else if (byte_in[OP_TXT_ADDR])
					begin
						ac_d    = byte_in[6:0];
						sel_d   = 1'b0;
						latch_d = txt_q[byte_in[6:0]];
					end
					else if (byte_in[OP_GLY_ADDR])
					begin
						ac_d    = {1'b0, byte_in[5:0]};
						sel_d   = 1'b1;
						latch_d = gly_q[byte_in[5:0]];
					end
					else if (byte_in[OP_FUNC])
					begin
						cfg_d.bus_width_select = byte_in[4];
						cfg_d.two_line         = byte_in[3];
						cfg_d.font_5x11        = byte_in[2];
						nib_d                  = 1'b0;
					end
					else if (byte_in[OP_SHIFT])
					begin
						// display shift leaves the counter unchanged
						if (!byte_in[3])
						begin
							ac_d = step_ac(ac_q, byte_in[2], sel_q,
								cfg_q.two_line);
							if (!sel_q)
								latch_d = txt_q[ac_d];
						end
					end
					else if (byte_in[OP_DISPLAY])
					begin
						cfg_d.display_on = byte_in[2];
						cfg_d.cursor_on  = byte_in[1];
						cfg_d.blink_on   = byte_in[0];
					end
					else if (byte_in[OP_ENTRY])
					begin
						cfg_d.increment = byte_in[1];
						cfg_d.shift_on  = byte_in[0];
					end
					else if (byte_in[OP_HOME])
					begin
						ac_d  = 7'h00;
						sel_d = 1'b0;
						cnt_d = CNT_W'(LONG_CYCLES);
					end
					else if (byte_in[OP_CLEAR])
					begin
						state_d         = ST_CLEAR;
						clr_d           = 7'h00;
						ac_d            = 7'h00;
						sel_d           = 1'b0;
						cfg_d.increment = 1'b1;
						cnt_d           = CNT_W'(LONG_CYCLES);
					end
				end
			end
			ST_EXEC:
			begin
				if (cnt_q <= CNT_W'(1))
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - CNT_W'(1);
			end
			ST_CLEAR:
			begin
				// one cell per cycle; the wait count runs afterwards
				txt_we = 1'b1;
				wa     = clr_q;
				wd     = SPACE_CODE;
				clr_d  = clr_q + 7'h01;
				if (clr_q == TXT_TOP)
					state_d = ST_EXEC;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state_q <= ST_CLEAR;
			cnt_q   <= CNT_W'(POR_CYCLES);
			clr_q   <= 7'h00;
			ac_q    <= 7'h00;
			sel_q   <= 1'b0;
			cfg_q   <= CFG_RESET;
			latch_q <= 8'h00;
			nib_q   <= 1'b0;
			hold_q  <= 4'h0;
			strb_q  <= 1'b0;
			dout_q  <= 8'h00;
			oe_q    <= 1'b0;
			busy_q  <= 1'b1;
			panel_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			clr_q   <= clr_d;
			ac_q    <= ac_d;
			sel_q   <= sel_d;
			cfg_q   <= cfg_d;
			latch_q <= latch_d;
			nib_q   <= nib_d;
			hold_q  <= hold_d;
			strb_q  <= i_host.strobe;
			dout_q  <= dout_d;
			oe_q    <= oe_d;
			busy_q  <= busy_d;
			panel_q <= panel_d;
		end
	end

	// ----------------------------------------------------------------
	// memories
	// ----------------------------------------------------------------
	// contents are not reset; the power-on clear fills the text memory
	for (genvar g = 0; g < TXT_DEPTH; g++)
	begin : g_txt
		always_ff @(posedge i_clk)
		begin
			if (txt_we && wa == 7'(g))
				txt_q[g] <= wd;
		end
	end
	for (genvar g = 0; g < GLY_DEPTH; g++)
	begin : g_gly
		always_ff @(posedge i_clk)
		begin
			if (gly_we && wa[5:0] == 6'(g))
				gly_q[g] <= wd;
		end
	end

	assign o_data_lines      = dout_q;
	assign o_data_lines_oe   = oe_q;
	assign o_busy_indicator  = busy_q;
	assign o_address_counter = ac_q;
	assign o_glyph_selected  = sel_q;
	assign o_cfg             = cfg_q;
	assign o_panel_code      = panel_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_busy_state: assert property (busy_q == (state_q != ST_IDLE))
		else $error("busy does not match execution state");
	a_busy_ignore: assert property (done && busy_q
		&& i_host.register_select |=> $stable(ac_q) && $stable(sel_q))
		else $error("transfer taken while busy");
	a_status_read: assert property (rise && i_host.read_write
		&& !i_host.register_select && cfg_q.bus_width_select
		|=> dout_q == {$past(busy_q), $past(ac_q)} && oe_q)
		else $error("status read value wrong");
	a_text_set: assert property (acc && !i_host.register_select
		&& byte_in[OP_TXT_ADDR] |=> ac_q == $past(byte_in[6:0]) && !sel_q)
		else $error("text address set failed");
	a_glyph_set: assert property (acc && !i_host.register_select
		&& byte_in[7:6] == 2'b01
		|=> ac_q == {1'b0, $past(byte_in[5:0])} && sel_q)
		else $error("glyph address set failed");
	a_step_up: assert property (acc && i_host.register_select
		&& cfg_q.increment && !sel_q && !cfg_q.two_line
		&& ac_q < TXT_ONE_LAST |=> ac_q == $past(ac_q) + 7'h01)
		else $error("counter did not step up");
	a_one_wrap: assert property (acc && i_host.register_select
		&& cfg_q.increment && !sel_q && !cfg_q.two_line
		&& ac_q == TXT_ONE_LAST |=> ac_q == 7'h00)
		else $error("one-line wrap wrong");
	a_two_gap: assert property (acc && i_host.register_select
		&& cfg_q.increment && !sel_q && cfg_q.two_line
		&& ac_q == TXT_L1_LAST |=> ac_q == TXT_L2_FIRST)
		else $error("two-line gap wrong");
	a_write_store: assert property (acc && i_host.register_select
		&& !i_host.read_write && !sel_q
		|=> txt_q[$past(ac_q)] == $past(byte_in))
		else $error("text write not stored");
	a_read_out: assert property (rise && i_host.read_write
		&& i_host.register_select && cfg_q.bus_width_select
		|=> dout_q == $past(latch_q))
		else $error("data read value wrong");
	a_exec_busy: assert property (acc |=> busy_q [*8])
		else $error("busy not held after accepted transfer");

	c_data_write: cover property (acc && i_host.register_select
		&& !i_host.read_write);
	c_four_bit: cover property (done && !cfg_q.bus_width_select);
	c_init_done: cover property ($fell(busy_q) && cfg_q == CFG_RESET);
	c_two_line: cover property (acc && cfg_q.two_line
		&& ac_q == TXT_L1_LAST);

endmodule

`default_nettype wire

/* File: logic/cla_core_dummy_guard.sv */
`default_nettype none
`default_nettype wire

/* File: test/cla_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cla_host_model
	import cla_pkg::*;
(
	// clock
	input  wire logic       i_clk,
	// device side of the bus
	input  wire logic [7:0] i_data_lines,
	input  wire logic       i_data_lines_oe,
	output var  cla_host_s  o_host
);
	logic       rs   = 1'b0;
	logic       rw   = 1'b1;
	logic       stb  = 1'b0;
	logic [7:0] drv  = 8'h00;
	logic       nib4 = 1'b0;
	logic [7:0] bus_w;

	// released lines carry the inverse of the last value, never a guess
	assign bus_w  = i_data_lines_oe ? i_data_lines : drv;
	assign o_host = '{rs, rw, stb, bus_w};

	// ----------------------------------------------------------------
	// one strobe pulse, held until the taking fall, then an idle cycle
	// ----------------------------------------------------------------
	task automatic pulse(input logic r, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		rs  = r;
		rw  = w;
		if (!w)
			drv = d;
		stb = 1'b1;
		@(posedge i_clk);
		#1;
		q   = bus_w;
		if (w)
			drv = ~q;
		stb = 1'b0;
		@(posedge i_clk);
		#1;
		if (!w)
			drv = ~drv;
		@(posedge i_clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// one byte, split in narrow mode
	// ----------------------------------------------------------------
	task automatic xfer(input logic r, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		logic [7:0] hi;
		logic [7:0] lo;
		if (nib4)
		begin
			pulse(r, w, {d[7:4], 4'h0}, hi);
			pulse(r, w, {d[3:0], 4'h0}, lo);
			q = {hi[7:4], lo[7:4]};
		end
		else
			pulse(r, w, d, q);
	endtask
	// callers poll busy and re-address before reads, except the read right after writing 8'h5a
	// no cursor shift is ever issued while the glyph memory is selected
endmodule

`default_nettype wire

/* File: test/cla_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module cla_tb_top
	import cla_pkg::*;
;
	localparam int POR = 40;
	logic       i_clk   = 1'b0;
	logic       i_rst_n = 1'b0;
	logic [3:0] pos     = 4'h0;
	cla_host_s  host;
	logic [7:0] dl;
	logic       oe;
	logic       busy;
	logic [6:0] ac;
	logic       gsel;
	cla_cfg_s   cfg;
	logic [7:0] pcode;
	logic [7:0] q;
	logic [7:0] stim[$];
	int         num_errors  = 0;
	int         checks_done = 0;
	int         cyc         = 0;
	int         txt[128];
	int         gly[64];
	int         m_ac, m_g, m_inc, m_two, m_lat;

	cla_core #(.EXEC_CYCLES(12), .LONG_CYCLES(20), .POR_CYCLES(POR))
	u_cla_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_host(host),
		.o_data_lines(dl), .o_data_lines_oe(oe),
		.o_busy_indicator(busy), .o_address_counter(ac),
		.o_glyph_selected(gsel), .o_cfg(cfg),
		.i_panel_pos(pos), .o_panel_code(pcode));

	cla_host_model u_cla_host_model (.i_clk(i_clk), .i_data_lines(dl),
		.i_data_lines_oe(oe), .o_host(host));

	initial
	begin
		forever #2 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
		if (i_rst_n)
			cyc++;

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic int nxt(int a);
		if (m_g)
			return (a + (m_inc ? 1 : 63)) % 64;
		if (!m_inc)
			return a == 0 ? (m_two ? 'h67 : 'h4f)
				: ((m_two && a == 'h40) ? 'h27 : a - 1);
		if (m_two && a == 'h27)
			return 'h40;
		if (a == (m_two ? 'h67 : 'h4f))
			return 0;
		return a + 1;
	endfunction

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// host operations
	// ----------------------------------------------------------------
	task automatic ready();
		int n;
		n = 0;
		q = 8'h80;
		while (q[7] !== 1'b0)
		begin
			u_cla_host_model.xfer(1'b0, 1'b1, 8'h00, q);
			n++;
			if (n > 300)
			begin
				num_errors++;
				$display("Error busy expected 0 seen 1");
				report_and_stop();
			end
		end
		chk("status_ac", 8'(m_ac), {1'b0, q[6:0]});
		chk("ac_port", 8'(m_ac), {1'b0, ac});
	endtask

	task automatic ins(input logic [7:0] b);
		ready();
		u_cla_host_model.xfer(1'b0, 1'b0, b, q);
	endtask

	task automatic aset(input int g, input int a);
		ins(g ? (8'h40 | 8'(a)) : (8'h80 | 8'(a)));
		m_g   = g;
		m_ac  = a;
		m_lat = g ? gly[a] : txt[a];
	endtask

	task automatic wr(input logic [7:0] d);
		ready();
		u_cla_host_model.xfer(1'b1, 1'b0, d, q);
		if (m_g)
			gly[m_ac] = d;
		else
			txt[m_ac] = d;
		m_ac = nxt(m_ac);
	endtask

	task automatic rd();
		ready();
		u_cla_host_model.xfer(1'b1, 1'b1, 8'h00, q);
		chk("read_data", 8'(m_lat), q);
		m_ac  = nxt(m_ac);
		m_lat = m_g ? gly[m_ac] : txt[m_ac];
	endtask

	task automatic panel();
		for (int p = 0; p < 16; p++)
		begin
			pos = 4'(p);
			@(posedge i_clk);
			#1;
			chk("panel", 8'(txt[(p / 8) * 64 + p % 8]), pcode);
		end
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h6e97add5));
		foreach (txt[i])
			txt[i] = 'h20;
		m_ac  = 0;
		m_g   = 0;
		m_inc = 1;
		m_two = 0;
		repeat (8) @(posedge i_clk);
		#1;
		i_rst_n = 1'b1;
		u_cla_host_model.xfer(1'b0, 1'b1, 8'h00, q);
		chk("por_busy", 8'h01, {7'h0, q[7]});
		ready();
		chk("por_time", 8'h01, {7'h0, cyc >= 128 + POR});
		chk("cfg", CFG_RESET, cfg);
		panel();
		$display("test power_on done");
		repeat (22) stim.push_back(8'($urandom));
		for (int k = 0; k < 2; k++)
		begin
			aset(0, k * 'h40);
			repeat (8) wr(stim.pop_front());
			aset(0, k * 'h40);
			repeat (8) rd();
		end
		panel();
		aset(0, 3);
		wr(8'h5a);
		rd();
		$display("test text done");
		aset(1, 'h3e);
		chk("glyph_sel", 8'h01, {7'h0, gsel});
		repeat (3) wr(stim.pop_front());
		aset(1, 'h3e);
		repeat (3) rd();
		$display("test glyph done");
		ins(8'h04);
		m_inc = 0;
		aset(0, 'h10);
		repeat (2) wr(stim.pop_front());
		ins(8'h06);
		m_inc = 1;
		aset(0, 'h4f);
		wr(8'h31);
		ins(8'h38);
		m_two = 1;
		ready();
		chk("two_line", 8'h01, {7'h0, cfg.two_line});
		aset(0, 'h27);
		wr(8'h32);
		aset(0, 'h67);
		wr(8'h33);
		ins(8'h30);
		m_two = 0;
		$display("test ranges done");
		aset(0, 'h20);
		wr(8'h44);
		u_cla_host_model.xfer(1'b0, 1'b1, 8'h00, q);
		chk("busy_after", 8'h01, {7'h0, q[7]});
		u_cla_host_model.xfer(1'b1, 1'b0, 8'hee, q);
		aset(0, 'h20);
		repeat (2) rd();
		aset(0, 'h40);
		ins(8'h14);
		m_ac  = 'h41;
		m_lat = txt['h41];
		rd();
		ins(8'h1c);
		ins(8'h02);
		m_ac = 0;
		m_g  = 0;
		$display("test busy_shift done");
		ins(8'h20);
		u_cla_host_model.nib4 = 1'b1;
		ready();
		chk("narrow", 8'h00, {7'h0, cfg.bus_width_select});
		aset(0, 5);
		wr(stim.pop_front());
		aset(0, 5);
		rd();
		ins(8'h30);
		u_cla_host_model.nib4 = 1'b0;
		$display("test narrow done");
		ins(8'h01);
		foreach (txt[i])
			txt[i] = 'h20;
		m_ac = 0;
		ready();
		panel();
		$display("test clear done");
		report_and_stop();
	end
endmodule

`default_nettype wire
